/* File: rtl/pit_core.sv */
// one timer channel: prescaler plus down-counter
// assumes control inputs synchronous to i_clk
`timescale 1ns/10ps
`include "pit_params.svh"
module pit_core #(
  parameter int PSC_W = `PIT_PSC_W,
  parameter int CNT_W = `PIT_CNT_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_stop,
  input  wire logic             i_reload,
  input  wire logic [PSC_W-1:0] i_divide,
  input  wire logic [CNT_W-1:0] i_period,
  output logic      [PSC_W-1:0] o_psc,
  output logic      [CNT_W-1:0] o_cnt,
  output logic                  o_tick
);
  logic [PSC_W-1:0] psc_q, psc_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             tick_q, tick_d;

  always_comb begin
    psc_d  = psc_q;
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (i_reload) begin
      psc_d = i_divide;
      cnt_d = i_period;
    end else if (!i_stop) begin
      if (psc_q == '0) begin
        psc_d = i_divide;
        if (cnt_q == '0) begin
          cnt_d  = i_period;
          tick_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end else begin
        psc_d = psc_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      psc_q  <= '0;
      cnt_q  <= '1;
      tick_q <= 1'b0;
    end else begin
      psc_q  <= psc_d;
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_psc  = psc_q;
  assign o_cnt  = cnt_q;
  assign o_tick = tick_q;

  // divide and period both zero tick on every cycle, so only a reload
  // value above zero forbids a second tick in a row
  a_tick_one_cycle: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (tick_q && (psc_q != '0 || cnt_q != '0)) |=> !tick_q)
    else $error("tick longer than one cycle");
  a_psc_decrement: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_stop && !i_reload && psc_q != '0) |=> psc_q == $past(psc_q) - 1'b1)
    else $error("prescale did not decrement");
  a_cnt_reload: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_stop && !i_reload && psc_q == '0 && cnt_q == '0)
    |=> tick_q && cnt_q == $past(i_period) && psc_q == $past(i_divide))
    else $error("underflow reload wrong");
  a_cnt_step: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_stop && !i_reload && psc_q == '0 && cnt_q != '0)
    |=> cnt_q == $past(cnt_q) - 1'b1 && !tick_q)
    else $error("counter did not step");
  a_stop_holds: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_stop && !i_reload) |=> $stable(cnt_q) && $stable(psc_q) && !tick_q)
    else $error("stopped timer moved");
  a_reload_load: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_reload |=> cnt_q == $past(i_period) && psc_q == $past(i_divide))
    else $error("reload not applied");
endmodule : pit_core

/* File: rtl/pit_params.svh */
// constants for the prescaled interval timer
// assumes inclusion by bare name from rtl files
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH
`define PIT_PSC_W        4
`define PIT_CNT_W        16
`define PIT_TIMERS       2
`define PIT_ADDR_W       12
`define PIT_REG_CTRL0    12'h000
`define PIT_REG_PERIOD0  12'h004
`define PIT_REG_STAT0    12'h008
`define PIT_REG_CTRL1    12'h010
`define PIT_REG_PERIOD1  12'h014
`define PIT_REG_STAT1    12'h018
`define PIT_REG_GPIO     12'h020
`define PIT_CTRL_STOP    4
`define PIT_CTRL_RELOAD  5
`define PIT_GPIO_HPEN    0
`define PIT_GPIO_OUT1EN  1
`define PIT_CTRL_RST     32'h0000_0010
`define PIT_PERIOD_RST   16'hFFFF
`endif

/* File: rtl/pit_pkg.sv */
// types for the prescaled interval timer
// assumes nothing of its surroundings
package pit_pkg;
  typedef enum logic [2:0] {
    PIT_IDLE  = 3'b001,
    PIT_SETUP = 3'b010,
    PIT_ACC   = 3'b100
  } pit_apb_st_t;
endpackage : pit_pkg

/* File: rtl/pit_top.sv */
// two prescaled interval timers behind an apb slave
// assumes apb master synchronous to i_clk, 32-bit data
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
`include "pit_params.svh"
module pit_top #(
  parameter int PSC_W = `PIT_PSC_W,
  parameter int CNT_W = `PIT_CNT_W
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`PIT_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output logic                        o_timer_interrupt_pulse0,
  output logic                        o_timer_interrupt_pulse1,
  output logic                        o_second_timer_output,
  output logic                        o_second_timer_output_oe
);
  localparam int N = `PIT_TIMERS;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [PSC_W-1:0] div_q [N], div_d [N];
  logic [CNT_W-1:0] per_q [N], per_d [N];
  logic             stop_q [N], stop_d [N];
  logic             rld_q [N], rld_d [N];
  logic [1:0]       gpio_q, gpio_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             ready_q, ready_d, err_q, err_d;
  logic [PSC_W-1:0] prescale_count [N];
  logic [CNT_W-1:0] cnt [N];
  logic             tick [N];
  logic             irq0_q, irq1_q, pin_q, oe_q;
  pit_pkg::pit_apb_st_t st_q, st_d;

  function automatic logic [31:0] ctrl_word(input logic [PSC_W-1:0] dv,
                                            input logic st,
                                            input logic rl);
    ctrl_word = 32'h0000_0000;
    ctrl_word[PSC_W-1:0] = dv;
    ctrl_word[`PIT_CTRL_STOP] = st;
    ctrl_word[`PIT_CTRL_RELOAD] = rl;
  endfunction : ctrl_word

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, access answered at second access edge
  always_comb begin
    st_d    = st_q;
    ready_d = 1'b0;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    gpio_d  = gpio_q;
    for (int i = 0; i < N; i++) begin
      div_d[i]  = div_q[i];
      per_d[i]  = per_q[i];
      stop_d[i] = stop_q[i];
      rld_d[i]  = 1'b0; // reload bit self clears after one cycle
    end
    case (st_q)
      pit_pkg::PIT_IDLE: begin
        if (i_psel && !i_penable) st_d = pit_pkg::PIT_SETUP;
      end
      pit_pkg::PIT_SETUP: begin
        if (i_psel && i_penable) begin
          st_d    = pit_pkg::PIT_ACC;
          ready_d = 1'b1;
          rdata_d = 32'h0000_0000;
          case (i_paddr)
            `PIT_REG_CTRL0:   rdata_d = ctrl_word(div_q[0], stop_q[0], 1'b0);
            `PIT_REG_PERIOD0: rdata_d = {16'h0000, per_q[0]};
            `PIT_REG_STAT0:   rdata_d = {12'h000, prescale_count[0], cnt[0]};
            `PIT_REG_CTRL1:   rdata_d = ctrl_word(div_q[1], stop_q[1], 1'b0);
            `PIT_REG_PERIOD1: rdata_d = {16'h0000, per_q[1]};
            `PIT_REG_STAT1:   rdata_d = {12'h000, prescale_count[1], cnt[1]};
            `PIT_REG_GPIO:    rdata_d = {30'h0, gpio_q};
            default:          err_d = 1'b1;
          endcase
          if (i_pwrite) begin
            case (i_paddr)
              `PIT_REG_CTRL0: begin
                div_d[0]  = i_pwdata[PSC_W-1:0];
                stop_d[0] = i_pwdata[`PIT_CTRL_STOP];
                rld_d[0]  = i_pwdata[`PIT_CTRL_RELOAD];
              end
              `PIT_REG_PERIOD0: per_d[0] = i_pwdata[CNT_W-1:0];
              `PIT_REG_CTRL1: begin
                div_d[1]  = i_pwdata[PSC_W-1:0];
                stop_d[1] = i_pwdata[`PIT_CTRL_STOP];
                rld_d[1]  = i_pwdata[`PIT_CTRL_RELOAD];
              end
              `PIT_REG_PERIOD1: per_d[1] = i_pwdata[CNT_W-1:0];
              `PIT_REG_GPIO:    gpio_d = i_pwdata[1:0];
              default:          ;
            endcase
          end
        end else if (!i_psel) begin
          st_d = pit_pkg::PIT_IDLE;
        end
      end
      pit_pkg::PIT_ACC: begin
        st_d = (i_psel && !i_penable) ? pit_pkg::PIT_SETUP
                                      : pit_pkg::PIT_IDLE;
      end
      default: st_d = pit_pkg::PIT_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q    <= pit_pkg::PIT_IDLE;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      gpio_q  <= 2'h1;
      for (int i = 0; i < N; i++) begin
        div_q[i]  <= '0;
        per_q[i]  <= `PIT_PERIOD_RST;
        stop_q[i] <= 1'b1;
        rld_q[i]  <= 1'b0;
      end
    end else begin
      st_q    <= st_d;
      ready_q <= ready_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
      gpio_q  <= gpio_d;
      for (int i = 0; i < N; i++) begin
        div_q[i]  <= div_d[i];
        per_q[i]  <= per_d[i];
        stop_q[i] <= stop_d[i];
        rld_q[i]  <= rld_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer channels
  for (genvar g = 0; g < N; g++) begin : g_tmr
    pit_core #(.PSC_W(PSC_W), .CNT_W(CNT_W)) u_core (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_stop   (stop_q[g]),
      .i_reload (rld_q[g]),
      .i_divide (div_q[g]),
      .i_period (per_q[g]),
      .o_psc    (prescale_count[g]),
      .o_cnt    (cnt[g]),
      .o_tick   (tick[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
      pin_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      irq0_q <= tick[0];
      irq1_q <= tick[1];
      pin_q  <= tick[1];
      oe_q   <= !gpio_q[`PIT_GPIO_HPEN] && gpio_q[`PIT_GPIO_OUT1EN];
    end
  end

  assign o_prdata                 = rdata_q;
  assign o_pready                 = ready_q;
  assign o_pslverr                = err_q;
  assign o_timer_interrupt_pulse0 = irq0_q;
  assign o_timer_interrupt_pulse1 = irq1_q;
  assign o_second_timer_output    = pin_q;
  assign o_second_timer_output_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pin_enabled;
    !gpio_q[`PIT_GPIO_HPEN] && gpio_q[`PIT_GPIO_OUT1EN];
  endsequence
  sequence s_apb_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_apb_access;
    i_psel && i_penable;
  endsequence
  sequence s_apb_take;
    st_q == pit_pkg::PIT_SETUP && i_psel && i_penable;
  endsequence

  a_pin_gate: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_pin_enabled |=> oe_q)
    else $error("pin not enabled");
  a_pin_off: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !(!gpio_q[`PIT_GPIO_HPEN] && gpio_q[`PIT_GPIO_OUT1EN]) |=> !oe_q)
    else $error("pin driven while host port on");
  a_pin_follow: assert property (
    @(posedge i_clk) disable iff (i_reset)
    tick[1] |=> pin_q)
    else $error("pin missed a timer 1 underflow");
  a_pin_quiet: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !tick[1] |=> !pin_q)
    else $error("pin high without underflow");
  a_irq_follow: assert property (
    @(posedge i_clk) disable iff (i_reset)
    tick[0] |=> irq0_q)
    else $error("irq0 missed an underflow");
  a_irq0_quiet: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !tick[0] |=> !irq0_q)
    else $error("irq0 high without underflow");
  a_irq1_follow: assert property (
    @(posedge i_clk) disable iff (i_reset)
    tick[1] |=> irq1_q)
    else $error("irq1 missed an underflow");
  a_irq1_quiet: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !tick[1] |=> !irq1_q)
    else $error("irq1 high without underflow");
  a_apb_answer: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take |=> ready_q)
    else $error("apb answer late");
  a_apb_two_step: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_setup ##1 s_apb_access |=> ready_q)
    else $error("access not answered after setup");
  a_ready_pulse: assert property (
    @(posedge i_clk) disable iff (i_reset)
    ready_q |=> !ready_q)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (
    @(posedge i_clk) disable iff (i_reset)
    err_q |-> ready_q && rdata_q == 32'h0000_0000)
    else $error("error without ready or with data");
  a_err_decode: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (i_paddr[1:0] != 2'h0) |=> err_q)
    else $error("unaligned address not refused");
  a_ctrl0_write: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (i_pwrite && i_paddr == `PIT_REG_CTRL0)
    |=> div_q[0] == $past(i_pwdata[PSC_W-1:0])
        && stop_q[0] == $past(i_pwdata[`PIT_CTRL_STOP])
        && rld_q[0] == $past(i_pwdata[`PIT_CTRL_RELOAD]))
    else $error("control word 0 not taken");
  a_ctrl1_write: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (i_pwrite && i_paddr == `PIT_REG_CTRL1)
    |=> div_q[1] == $past(i_pwdata[PSC_W-1:0])
        && stop_q[1] == $past(i_pwdata[`PIT_CTRL_STOP])
        && rld_q[1] == $past(i_pwdata[`PIT_CTRL_RELOAD]))
    else $error("control word 1 not taken");
  a_period0_write: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (i_pwrite && i_paddr == `PIT_REG_PERIOD0)
    |=> per_q[0] == $past(i_pwdata[CNT_W-1:0]))
    else $error("period 0 not taken");
  a_period1_write: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (i_pwrite && i_paddr == `PIT_REG_PERIOD1)
    |=> per_q[1] == $past(i_pwdata[CNT_W-1:0]))
    else $error("period 1 not taken");
  a_gpio_write: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (i_pwrite && i_paddr == `PIT_REG_GPIO)
    |=> gpio_q == $past(i_pwdata[1:0]))
    else $error("pin control not taken");
  a_regs_hold: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !(st_q == pit_pkg::PIT_SETUP && i_psel && i_penable)
    |=> $stable(div_q[0]) && $stable(stop_q[0]) && $stable(per_q[0])
        && $stable(div_q[1]) && $stable(stop_q[1]) && $stable(per_q[1])
        && $stable(gpio_q))
    else $error("register changed outside a write");
  a_rld_pulse0: assert property (
    @(posedge i_clk) disable iff (i_reset)
    rld_q[0] |=> !rld_q[0])
    else $error("reload 0 longer than one cycle");
  a_rld_pulse1: assert property (
    @(posedge i_clk) disable iff (i_reset)
    rld_q[1] |=> !rld_q[1])
    else $error("reload 1 longer than one cycle");
  a_stat0_read: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (!i_pwrite && i_paddr == `PIT_REG_STAT0)
    |=> rdata_q == {12'h000, $past(prescale_count[0]), $past(cnt[0])})
    else $error("status 0 read wrong");
  a_stat1_read: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (!i_pwrite && i_paddr == `PIT_REG_STAT1)
    |=> rdata_q == {12'h000, $past(prescale_count[1]), $past(cnt[1])})
    else $error("status 1 read wrong");
  a_period0_read: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_apb_take ##0 (!i_pwrite && i_paddr == `PIT_REG_PERIOD0)
    |=> rdata_q == {16'h0000, $past(per_q[0])})
    else $error("period 0 read wrong");
endmodule : pit_top

/* File: tb/prescaled_interval_timer_bench.sv */
// self-checking bench for the two-channel prescaled interval timer
// assumes pit_top with its apb slave, clocked at 100 MHz
`timescale 1ns/10ps
`include "pit_params.svh"
module prescaled_interval_timer_bench;
  typedef struct packed {
    logic        rd;
    logic [31:0] d;
    logic        e;
  } pit_exp_t;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq0;
  logic        irq1;
  logic        tout;
  logic        tout_oe;
  pit_exp_t    exp_q[$];
  pit_exp_t    cur;
  int          errors;
  int          n_tests;
  int          seed;
  logic [31:0] d0, p0, d1, p1;
  int          n;

  pit_top u_pit_top (
    .i_clk                    (clk),
    .i_reset                  (rst),
    .i_psel                   (psel),
    .i_penable                (penable),
    .i_pwrite                 (pwrite),
    .i_paddr                  (paddr),
    .i_pwdata                 (pwdata),
    .o_prdata                 (prdata),
    .o_pready                 (pready),
    .o_pslverr                (pslverr),
    .o_timer_interrupt_pulse0 (irq0),
    .o_timer_interrupt_pulse1 (irq1),
    .o_second_timer_output    (tout),
    .o_second_timer_output_oe (tout_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] x, input logic xe);
    int k;
    exp_q.push_back({~wr, x, xe});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0, x, xe);
  endtask : rd

  // the first pulse may be left over from the old setting, so it and
  // the gap after it are skipped; the gap between the next two counts
  task meas(input logic sel, input logic [31:0] x);
    int k;
    k = 0;
    for (int i = 0; i < 3; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while ((sel ? irq1 : irq0) !== 1'b1 && k < 5000);
    end
    chk(k, x);
    if (sel) chk({31'h0, tout}, 32'h1);
  endtask : meas

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (pready === 1'b1 && psel && penable) begin
      if (exp_q.size() == 0) begin
        errors++;
      end else begin
        cur = exp_q.pop_front();
        if (cur.rd) chk(prdata, cur.d);
        chk({31'h0, pslverr}, {31'h0, cur.e});
      end
    end
  end

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 14120;
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk({28'h0, irq0, irq1, tout, tout_oe}, 32'h0);
    rd(`PIT_REG_CTRL0, 32'h10, 1'b0);
    rd(`PIT_REG_PERIOD0, 32'hFFFF, 1'b0);
    rd(`PIT_REG_STAT0, 32'hFFFF, 1'b0);
    rd(`PIT_REG_CTRL1, 32'h10, 1'b0);
    rd(`PIT_REG_PERIOD1, 32'hFFFF, 1'b0);
    rd(`PIT_REG_STAT1, 32'hFFFF, 1'b0);
    rd(`PIT_REG_GPIO, 32'h1, 1'b0);
    rd(12'h00C, 32'h0, 1'b1);
    apb(1'b1, 12'h024, 32'hFFFF_FFFF, 32'h0, 1'b1);
    rd(`PIT_REG_GPIO, 32'h1, 1'b0);
    $display("test reset done");
    wr(`PIT_REG_PERIOD0, 32'h0);
    for (int d = 0; d < 16; d++) begin
      wr(`PIT_REG_CTRL0, 32'h20 | d);
      meas(1'b0, d + 1);
    end
    $display("test divide done");
    repeat (4) begin
      d0 = $random(seed) & 15;
      p0 = $random(seed) & 15;
      d1 = $random(seed) & 15;
      p1 = $random(seed) & 15;
      wr(`PIT_REG_PERIOD0, p0);
      wr(`PIT_REG_CTRL0, 32'h20 | d0);
      wr(`PIT_REG_PERIOD1, p1);
      wr(`PIT_REG_CTRL1, 32'h20 | d1);
      rd(`PIT_REG_PERIOD1, p1, 1'b0);
      meas(1'b0, (d0 + 1) * (p0 + 1));
      meas(1'b1, (d1 + 1) * (p1 + 1));
    end
    $display("test random done");
    wr(`PIT_REG_PERIOD0, 32'h0123);
    wr(`PIT_REG_CTRL0, 32'h32);
    rd(`PIT_REG_STAT0, 32'h0002_0123, 1'b0);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      if (irq0 === 1'b1) n++;
    end
    chk(n, 0);
    rd(`PIT_REG_STAT0, 32'h0002_0123, 1'b0);
    rd(`PIT_REG_CTRL0, 32'h12, 1'b0);
    wr(`PIT_REG_CTRL0, 32'h22);
    meas(1'b0, 3 * 32'h124);
    $display("test stop done");
    for (int g = 0; g < 4; g++) begin
      wr(`PIT_REG_GPIO, g);
      repeat (2) @(posedge clk);
      chk({31'h0, tout_oe}, {31'h0, g == 2});
      rd(`PIT_REG_GPIO, g, 1'b0);
    end
    $display("test pin done");
    end_sim;
  end
endmodule : prescaled_interval_timer_bench
